/* File: include/pbg_pkg.sv */
// constants, state layout and helper functions of the port b gpio block
// assumes a 32-bit classic wishbone slave port on a 125 MHz clock
package pbg_pkg;

  // ****************************************
  // bus geometry and register indices
  // ****************************************
  localparam int          ADR_W    = 18;
  localparam int          DAT_W    = 32;
  localparam logic [15:0] DIR_IDX  = 16'hffd4;
  localparam logic [15:0] LAT_IDX  = 16'hffd6;
  localparam logic [15:0] FUNC_IDX = 16'hffd8;
  localparam logic [15:0] DMA_IDX  = 16'hffda;
  localparam logic [17:0] DIR_ADR  = {DIR_IDX, 2'b00};
  localparam logic [17:0] LAT_ADR  = {LAT_IDX, 2'b00};
  localparam logic [17:0] FUNC_ADR = {FUNC_IDX, 2'b00};
  localparam logic [17:0] DMA_ADR  = {DMA_IDX, 2'b00};

  // ****************************************
  // reset and read values
  // ****************************************
  localparam logic [7:0]  DIR_RST  = 8'h00;
  localparam logic [7:0]  LAT_RST  = 8'h00;
  localparam logic [7:0]  DIR_READ = 8'hff;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FN_PAT   = 0;   // pattern_enable_12..15 at bits 3:0
  localparam int FN_TRIG  = 4;   // ad_trigger_enable
  localparam int FN_CSEL  = 5;   // chip_select_seven_enable
  localparam int FN_TMR_A = 6;   // timer4_comp_a_output_enable
  localparam int FN_TMR_B = 7;   // timer4_comp_b_output_enable
  localparam int FN_CMD   = 8;   // timer_combination_mode_bit
  localparam int DMA_CH0  = 0;   // channel 0 source fields at bits 4:0
  localparam int DMA_CH1  = 8;   // channel 1 source fields at bits 12:8
  localparam int SRC_A2   = 4;   // transfer_source_a_bit2
  localparam int SRC_A1   = 3;
  localparam int SRC_A0   = 2;
  localparam int SRC_B2   = 1;   // transfer_source_b_bit2
  localparam int SRC_B1   = 0;
  localparam int PIN_SH   = 4;   // lowest shared pin
  localparam int PIN_TB   = 5;
  localparam int PIN_TA   = 4;
  localparam int PIN_CS   = 6;
  localparam int PIN_AD   = 7;

  // ****************************************
  // state of the block
  // ****************************************
  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  lat;
    logic [8:0]  func;
    logic [4:0]  dma0;
    logic [4:0]  dma1;
    logic        ack;
    logic [15:0] rdat;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe;
    logic        trig_n;
    logic        req1_n;
    logic        req0_n;
  } pbg_state_t;

  localparam pbg_state_t ST_RST = '{trig_n: 1'b1, req1_n: 1'b1, req0_n: 1'b1, default: '0};

  // external request mode decode of one dma channel's source fields
  function automatic logic ext_req(input logic [4:0] f);
    if (!(f[SRC_A2] && f[SRC_A1]))
      return f[SRC_B2] & f[SRC_B1];
    return f[SRC_B2] & (!f[SRC_A0] | f[SRC_B1]);
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_wr(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] sel);
    return {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

endpackage

/* File: hdl/pbg_port.sv */
// port b gpio with pin function mux for pins 7 to 4
// assumes classic wishbone master, pins synchronous to clk_in, standby levels from power control
// What this block does
// - eight two-way pins, all inputs after reset or on entering hardware standby.
// - direction bit n set makes pin n an output, cleared makes it an input.
// - the direction register is write-only and reads back as all ones.
// - the direction register clears on reset and hardware standby and holds in software standby.
// - in software standby every output pin keeps driving its current level.
// - a data read returns the latch bit where the direction bit is set and the pin level where it is clear.
// - the data latch clears on reset and hardware standby and holds in software standby.
// - pin 7 is an input, a port output, or pattern output 15 by direction and pattern enable.
// - pin 7 feeds the a/d trigger input whenever the trigger enable is set.
// - pin 7 feeds the channel 1 dma request when channel 1 selects external requests.
// - pin 6 drives chip select 7 when enabled, else selects like pin 7 with pattern output 14.
// - pin 6 feeds the channel 0 dma request when channel 0 selects external requests.
// - pin 5 drives timer 4 output b when its enable and combination mode are set, else pattern 13.
// - pin 4 drives timer 4 output a when its enable and combination mode are set, else pattern 12.
`timescale 1ns/1ns

module pbg_port
(
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    hw_standby_in,
  input  wire logic                    sw_standby_in,
  input  wire logic                    cyc_in,
  input  wire logic                    stb_in,
  input  wire logic                    we_in,
  input  wire logic [pbg_pkg::ADR_W-1:0] adr_in,
  input  wire logic [3:0]              sel_in,
  input  wire logic [pbg_pkg::DAT_W-1:0] dat_in,
  output logic [pbg_pkg::DAT_W-1:0]    dat_out,
  output logic                         ack_out,
  input  wire logic [7:0]              pin_in,
  output logic [7:0]                   pin_out,
  output logic [7:0]                   pin_oe_out,
  input  wire logic [3:0]              pattern_out_in,
  input  wire logic                    chip_select_seven_n_in,
  input  wire logic                    timer4_complementary_out_a_in,
  input  wire logic                    timer4_complementary_out_b_in,
  output logic                         ad_external_trigger_n_out,
  output logic                         dma_request_ch1_n_out,
  output logic                         dma_request_ch0_n_out
);
  import pbg_pkg::*;

  // ****************************************
  // state registers
  // ****************************************
  pbg_state_t s_q;
  pbg_state_t s_d;
  logic       hit;
  logic [1:0] sel;
  logic [1:0] ps;
  logic [15:0] wd;
  logic [15:0] mrg;  // byte-lane merged write value

  // ****************************************
  // next state
  // ****************************************

  // bus decode, register writes and pin function selection
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    hit = cyc_in && stb_in && !s_q.ack;
    sel = sel_in[1:0];
    wd = dat_in[15:0];
    ps = 2'b00;
    mrg = '0;
    if (hit)
    begin
      s_d.ack = 1'b1;
      s_d.rdat = '0;
      if (adr_in == DIR_ADR)
      begin
        s_d.rdat[7:0] = DIR_READ;
        if (we_in && sel[0])
          s_d.dir = wd[7:0];
      end
      else if (adr_in == LAT_ADR)
      begin
        s_d.rdat[7:0] = (s_q.lat & s_q.dir) | (pin_in & ~s_q.dir);
        if (we_in && sel[0])
          s_d.lat = wd[7:0];
      end
      else if (adr_in == FUNC_ADR)
      begin
        s_d.rdat = {7'h00, s_q.func};
        if (we_in)
        begin
          mrg = lane_wr({7'h00, s_q.func}, wd, sel);
          s_d.func = mrg[8:0];
        end
      end
      else if (adr_in == DMA_ADR)
      begin
        s_d.rdat = {3'h0, s_q.dma1, 3'h0, s_q.dma0};
        if (we_in)
        begin
          mrg = lane_wr(s_d.rdat, wd, sel);
          s_d.dma0 = mrg[DMA_CH0 +: 5];
          s_d.dma1 = mrg[DMA_CH1 +: 5];
        end
      end
    end
    // pins freeze in software standby
    if (!sw_standby_in)
    begin
      s_d.pin_oe = s_q.dir;
      s_d.pin_o = s_q.lat;
      for (int i = 0; i < 4; i++)
      begin
        ps = {s_q.dir[PIN_SH+i],
              s_q.func[FN_PAT+i] ? pattern_out_in[i] : s_q.lat[PIN_SH+i]};
        s_d.pin_oe[PIN_SH+i] = ps[1];
        s_d.pin_o[PIN_SH+i] = ps[0];
      end
      if (s_q.func[FN_CSEL])
      begin
        s_d.pin_oe[PIN_CS] = 1'b1;
        s_d.pin_o[PIN_CS] = chip_select_seven_n_in;
      end
      if (s_q.func[FN_TMR_B] && s_q.func[FN_CMD])
      begin
        s_d.pin_oe[PIN_TB] = 1'b1;
        s_d.pin_o[PIN_TB] = timer4_complementary_out_b_in;
      end
      if (s_q.func[FN_TMR_A] && s_q.func[FN_CMD])
      begin
        s_d.pin_oe[PIN_TA] = 1'b1;
        s_d.pin_o[PIN_TA] = timer4_complementary_out_a_in;
      end
    end
    // inputs routed to other units, idle high when not selected
    s_d.trig_n = s_q.func[FN_TRIG] ? pin_in[PIN_AD] : 1'b1;
    s_d.req1_n = ext_req(s_q.dma1) ? pin_in[PIN_AD] : 1'b1;
    s_d.req0_n = ext_req(s_q.dma0) ? pin_in[PIN_CS] : 1'b1;
    // hardware standby reinitialises everything
    if (hw_standby_in)
      s_d = ST_RST;
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s_q <= ST_RST;
    else
      s_q <= s_d;
  end

  // ****************************************
  // outputs
  // ****************************************

  // all outputs straight from the state register
  assign dat_out                   = {16'h0000, s_q.rdat};
  assign ack_out                   = s_q.ack;
  assign pin_out                   = s_q.pin_o;
  assign pin_oe_out                = s_q.pin_oe;
  assign ad_external_trigger_n_out = s_q.trig_n;
  assign dma_request_ch1_n_out     = s_q.req1_n;
  assign dma_request_ch0_n_out     = s_q.req0_n;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  hw_standby_in_a: assert property (
    hw_standby_in |=> pin_oe_out == 8'h00 && ack_out == 1'b0)
    else $error("pins not inputs after hardware standby");

  hw_clear_regs_a: assert property (
    hw_standby_in |=> s_q.dir == DIR_RST && s_q.lat == LAT_RST)
    else $error("registers not cleared by hardware standby");

  dir_read_a: assert property (
    cyc_in && stb_in && !ack_out && !we_in && adr_in == DIR_ADR && !hw_standby_in
    |=> ack_out && dat_out[7:0] == DIR_READ)
    else $error("direction read not all ones");

  data_read_a: assert property (
    cyc_in && stb_in && !ack_out && !we_in && adr_in == LAT_ADR && !hw_standby_in
    |=> dat_out[7:0] == (($past(s_q.lat) & $past(s_q.dir)) | ($past(pin_in) & ~$past(s_q.dir))))
    else $error("data read mixes latch and pins wrongly");

  latch_write_a: assert property (
    cyc_in && stb_in && !ack_out && we_in && sel_in[0] && adr_in == LAT_ADR && !hw_standby_in
    |=> s_q.lat == $past(dat_in[7:0]))
    else $error("latch write lost");

  sw_hold_pins_a: assert property (
    sw_standby_in && !hw_standby_in ##1 sw_standby_in && !hw_standby_in
    |-> $stable(pin_out) && $stable(pin_oe_out))
    else $error("pins moved in software standby");

  pin7_dir_a: assert property (
    !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_AD] == $past(s_q.dir[PIN_AD])
        && (!pin_oe_out[PIN_AD] || pin_out[PIN_AD] ==
            ($past(s_q.func[FN_PAT+3]) ? $past(pattern_out_in[3]) : $past(s_q.lat[PIN_AD]))))
    else $error("pin 7 function select wrong");

  csel_override_a: assert property (
    s_q.func[FN_CSEL] && !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_CS] && pin_out[PIN_CS] == $past(chip_select_seven_n_in))
    else $error("chip select 7 not driven");

  timer_a_pin_a: assert property (
    s_q.func[FN_TMR_A] && s_q.func[FN_CMD] && !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_TA] && pin_out[PIN_TA] == $past(timer4_complementary_out_a_in))
    else $error("timer output a not on pin 4");

  timer_b_pin_a: assert property (
    s_q.func[FN_TMR_B] && s_q.func[FN_CMD] && !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_TB] && pin_out[PIN_TB] == $past(timer4_complementary_out_b_in))
    else $error("timer output b not on pin 5");

  ad_trigger_a: assert property (
    s_q.func[FN_TRIG] && !hw_standby_in
    |=> ad_external_trigger_n_out == $past(pin_in[PIN_AD]))
    else $error("a/d trigger not fed from pin 7");

  dma_req1_a: assert property (
    ext_req(s_q.dma1) && !hw_standby_in |=> dma_request_ch1_n_out == $past(pin_in[PIN_AD]))
    else $error("dma channel 1 request not fed from pin 7");

  dma_req0_a: assert property (
    ext_req(s_q.dma0) && !hw_standby_in |=> dma_request_ch0_n_out == $past(pin_in[PIN_CS]))
    else $error("dma channel 0 request not fed from pin 6");

  // ****************************************
  // bus side checks
  // ****************************************

  ack_pulse_a: assert property (
    ack_out |=> !ack_out)
    else $error("bus acknowledge longer than one cycle");

  dir_write_a: assert property (
    cyc_in && stb_in && !ack_out && we_in && sel_in[0] && adr_in == DIR_ADR && !hw_standby_in
    |=> s_q.dir == $past(dat_in[7:0]))
    else $error("direction write lost");

  dir_read_high_a: assert property (
    cyc_in && stb_in && !ack_out && !we_in && adr_in == DIR_ADR && !hw_standby_in
    |=> dat_out[DAT_W-1:8] == '0)
    else $error("direction read upper bits not zero");

  unmapped_read_a: assert property (
    cyc_in && stb_in && !ack_out && !hw_standby_in && adr_in != DIR_ADR && adr_in != LAT_ADR
    && adr_in != FUNC_ADR && adr_in != DMA_ADR |=> ack_out && dat_out == '0)
    else $error("unmapped read not zero");

  latch_keep_a: assert property (
    cyc_in && stb_in && !ack_out && we_in && adr_in == DIR_ADR && !hw_standby_in
    |=> $stable(s_q.lat))
    else $error("latch moved by a direction write");

  sw_keep_regs_a: assert property (
    sw_standby_in && !hw_standby_in && !(cyc_in && stb_in && !ack_out && we_in)
    |=> $stable(s_q.dir) && $stable(s_q.lat))
    else $error("registers moved in software standby");

  hw_req_idle_a: assert property (
    hw_standby_in
    |=> ad_external_trigger_n_out && dma_request_ch1_n_out && dma_request_ch0_n_out)
    else $error("routed inputs not idle after hardware standby");

  // ****************************************
  // pin side checks
  // ****************************************

  low_pins_dir_a: assert property (
    !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_SH-1:0] == $past(s_q.dir[PIN_SH-1:0]))
    else $error("pins 3 to 0 direction wrong");

  low_pins_out_a: assert property (
    !sw_standby_in && !hw_standby_in
    |=> pin_out[PIN_SH-1:0] == $past(s_q.lat[PIN_SH-1:0]))
    else $error("pins 3 to 0 not driven from the latch");

  pin6_select_a: assert property (
    !s_q.func[FN_CSEL] && !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_CS] == $past(s_q.dir[PIN_CS])
        && (!pin_oe_out[PIN_CS] || pin_out[PIN_CS] ==
            ($past(s_q.func[FN_PAT+2]) ? $past(pattern_out_in[2]) : $past(s_q.lat[PIN_CS]))))
    else $error("pin 6 function select wrong");

  pin5_select_a: assert property (
    !(s_q.func[FN_TMR_B] && s_q.func[FN_CMD]) && !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_TB] == $past(s_q.dir[PIN_TB])
        && (!pin_oe_out[PIN_TB] || pin_out[PIN_TB] ==
            ($past(s_q.func[FN_PAT+1]) ? $past(pattern_out_in[1]) : $past(s_q.lat[PIN_TB]))))
    else $error("pin 5 function select wrong");

  pin4_select_a: assert property (
    !(s_q.func[FN_TMR_A] && s_q.func[FN_CMD]) && !sw_standby_in && !hw_standby_in
    |=> pin_oe_out[PIN_TA] == $past(s_q.dir[PIN_TA])
        && (!pin_oe_out[PIN_TA] || pin_out[PIN_TA] ==
            ($past(s_q.func[FN_PAT]) ? $past(pattern_out_in[0]) : $past(s_q.lat[PIN_TA]))))
    else $error("pin 4 function select wrong");

  trig_idle_a: assert property (
    !s_q.func[FN_TRIG] |=> ad_external_trigger_n_out)
    else $error("a/d trigger not idle while disabled");

  req1_idle_a: assert property (
    !ext_req(s_q.dma1) |=> dma_request_ch1_n_out)
    else $error("dma channel 1 request not idle");

  req0_idle_a: assert property (
    !ext_req(s_q.dma0) |=> dma_request_ch0_n_out)
    else $error("dma channel 0 request not idle");

endmodule

/* File: bench/pbg_board.sv */
// board model of the eight port b pins
// assumes pin_oe_out high means the block drives the pin
`timescale 1ns/1ns

module pbg_board
(
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] ext_in,
  output logic [7:0]      level_out
);
  // driven pins show the block level, released pins the board level
  assign level_out = (drive_in & oe_in) | (ext_in & ~oe_in);
endmodule

/* File: bench/port_b_gpio_pin_mux_test.sv */
// self-checking bench of the port b gpio block
// assumes pbg_pkg, pbg_port and pbg_board compiled first
`timescale 1ns/1ns

module port_b_gpio_pin_mux_test;
  import pbg_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic             clk_in = 0, nrst_in = 0, hws = 0, sws = 0, cyc = 0, stb = 0, we = 0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0]       sel = '0, pat = '0;
  logic [DAT_W-1:0] wdat = '0, rdat;
  logic             ack, ad_n, rq1_n, rq0_n, cs_n = 1, ta = 0, tb = 0;
  logic [7:0]       lvl, po, poe, ext = '0, v, l, d;
  logic [31:0]      expq[$], q;
  logic [15:0]      mode [3] = '{16'h0303, 16'h1b1b, 16'h1f1f};
  int               err_count = 0, compares = 0;

  pbg_port dut (.clk_in(clk_in), .nrst_in(nrst_in), .hw_standby_in(hws), .sw_standby_in(sws),
    .cyc_in(cyc), .stb_in(stb), .we_in(we), .adr_in(adr), .sel_in(sel), .dat_in(wdat),
    .dat_out(rdat), .ack_out(ack), .pin_in(lvl), .pin_out(po), .pin_oe_out(poe),
    .pattern_out_in(pat), .chip_select_seven_n_in(cs_n), .timer4_complementary_out_a_in(ta),
    .timer4_complementary_out_b_in(tb), .ad_external_trigger_n_out(ad_n),
    .dma_request_ch1_n_out(rq1_n), .dma_request_ch0_n_out(rq0_n));
  pbg_board board (.drive_in(po), .oe_in(poe), .ext_in(ext), .level_out(lvl));

  // free running clock
  always #4 clk_in = ~clk_in;

  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // classic single wishbone cycle, read notes go to the queue
  task wb(logic w, logic [ADR_W-1:0] a, logic [15:0] dv, logic [15:0] m);
    if (!w)
      expq.push_back({m, dv});
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0, dv};
    // no timeout here: the wait ends on the acknowledge, or at the watchdog if none comes
    do
      @(posedge clk_in);
    while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_in);
  endtask

  // pin drive settles two edges after the cause
  task pins(logic [7:0] oe, logic [7:0] o, logic [7:0] m);
    repeat (2) @(posedge clk_in);
    #1;
    chk("pin_oe", poe, oe);
    chk("pin_out", po & m, o & m);
    @(posedge clk_in);
  endtask

  task end_sim;
    chk("pending", 16'(expq.size()), 16'h0);
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // result watcher: oldest note against each acknowledged read
  always @(posedge clk_in)
    if (ack === 1'b1 && !we && expq.size() > 0)
    begin
      q = expq.pop_front();
      chk("rdat", rdat[15:0] & q[31:16], q[15:0]);
    end

  // watchdog against a hung handshake
  initial
  begin
    #40000;
    err_count++;
    end_sim;
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'h760d));
    repeat (8) @(posedge clk_in);
    nrst_in <= 1;
    ext <= 8'h5a;
    @(posedge clk_in);
    #1;
    chk("oe_rst", poe, 8'h00);
    chk("req_rst", {ad_n, rq1_n, rq0_n}, 3'b111);
    @(posedge clk_in);
    wb(0, DIR_ADR, 16'h00ff, 16'h00ff);
    wb(0, LAT_ADR, 16'h005a, 16'h00ff);
    wb(1, DIR_ADR, 16'h00ff, 0);
    wb(0, LAT_ADR, 16'h0000, 16'h00ff);
    wb(0, 18'h00010, 16'h0000, 16'hffff);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      l = 8'($urandom);
      d = 8'($urandom);
      ext <= v;
      wb(1, DIR_ADR, 16'h0000, 0);
      wb(1, LAT_ADR, {8'h0, l}, 0);
      wb(1, DIR_ADR, {8'h0, d}, 0);
      wb(0, LAT_ADR, {8'h0, (l & d) | (v & ~d)}, 16'h00ff);
      pins(d, l, d);
      wb(0, DIR_ADR, 16'h00ff, 16'h00ff);
    end
    $display("test direction done");
    pat <= 4'($urandom);
    wb(1, DIR_ADR, 16'h00f0, 0);
    wb(1, FUNC_ADR, 16'h000f, 0);
    pins(8'hf0, {pat, 4'h0}, 8'hf0);
    wb(1, DIR_ADR, 16'h0000, 0);
    pins(8'h00, 8'h00, 8'h00);
    cs_n <= 1'($urandom);
    ta <= 1'($urandom);
    tb <= 1'($urandom);
    wb(1, FUNC_ADR, 16'h01e0, 0);
    pins(8'h70, {1'b0, cs_n, tb, ta, 4'h0}, 8'h70);
    wb(1, FUNC_ADR, 16'h00c0, 0);
    pins(8'h00, 8'h00, 8'h00);
    $display("test pin mux done");
    wb(1, FUNC_ADR, 16'h0010, 0);
    for (int i = 0; i < 3; i++)
    begin
      v = 8'($urandom);
      ext <= v;
      wb(1, DMA_ADR, mode[i], 0);
      pins(8'h00, 8'h00, 8'h00);
      chk("req", {ad_n, rq1_n, rq0_n}, {v[7], v[7], v[6]});
    end
    ext <= 8'h00;
    wb(1, DMA_ADR, 16'h0202, 0);
    pins(8'h00, 8'h00, 8'h00);
    chk("req_off", {rq1_n, rq0_n}, 2'b11);
    // both a-side bits set with the low a bit set and low b bit clear: no external request
    wb(1, DMA_ADR, 16'h1e1e, 0);
    pins(8'h00, 8'h00, 8'h00);
    chk("req_off2", {rq1_n, rq0_n}, 2'b11);
    $display("test requests done");
    wb(1, FUNC_ADR, 16'h0000, 0);
    wb(1, DIR_ADR, 16'h00ff, 0);
    wb(1, LAT_ADR, {8'h0, l}, 0);
    pins(8'hff, l, 8'hff);
    sws <= 1;
    wb(1, LAT_ADR, {8'h0, ~l}, 0);
    pins(8'hff, l, 8'hff);
    wb(0, LAT_ADR, {8'h0, ~l}, 16'h00ff);
    sws <= 0;
    pins(8'hff, ~l, 8'hff);
    hws <= 1;
    @(posedge clk_in);
    hws <= 0;
    pins(8'h00, 8'h00, 8'h00);
    wb(1, DIR_ADR, 16'h00ff, 0);
    wb(0, LAT_ADR, 16'h0000, 16'h00ff);
    $display("test standby done");
    end_sim;
  end
endmodule
